/* core/rcoc_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Jitter skip acts only when a recovered channel clock is chosen.
// - Skip at 0 (default) takes recovered clock from the jitter attenuator.
// - Skip at 1 takes recovered clock straight from clock recovery.
// - Holdover acts only on loss; ignored for output A on external input.
// - Output B lost, holdover 0: free-runs at the T1 or E1 line rate.
// - Synth skip 0 routes output A through the synthesizer, 1 around it.
// - Free-run acts only when output A goes through the synthesizer.
// - Free-run 0: output A locked to its source at the coded rate.
// - Free-run 1: output A free-runs from the master clock at the coded rate.
// - External A lost: free-runs if synth on and free-run 1, else high.
// - Channel lost, synth on, free-run 0: holdover 0 free-runs, 1 high.
// - Channel lost, synth skipped: holdover 0 line-rate free-run, 1 high.
// - The rate code applies only while the synthesizer is in use.
// - Locked code 000 gives the source rate; code 011 is reserved.
// - Locked codes give 8k, 64k, 4.096M, 8.192M, 19.44M, 32.768M Hz.
// - Free-running uses the same rates; codes 000 and 011 are undefined.
module rcoc_top (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [rcoc_pkg::RCOC_ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Source selection and type from neighbouring registers.
    input wire logic [4:0] src_sel_a_in,
    input wire logic [4:0] src_sel_b_in,
    input wire logic ext_a_is_e1_in,
    input wire logic ext_b_is_e1_in,
    input wire logic line_is_e1_in,
    // Loss of the selected source, from the clock monitors.
    input wire logic loss_a_in,
    input wire logic loss_b_in,
    // Reference output A control.
    output rcoc_pkg::rcoc_a_mode_t ref_a_mode_out,
    output logic [2:0] ref_a_rate_code_out,
    output logic [31:0] ref_a_freq_hz_out,
    output logic ref_a_code_undefined_out,
    output logic ref_a_ja_skip_out,
    // Reference output B control.
    output rcoc_pkg::rcoc_b_mode_t ref_b_mode_out,
    output logic [31:0] ref_b_freq_hz_out,
    output logic ref_b_ja_skip_out
);
    import rcoc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Source classification for both outputs.
    rcoc_src_if src_a ();
    rcoc_src_if src_b ();

    rcoc_src_monitor u_src_a (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .src_sel_in(src_sel_a_in),
        .ext_is_e1_in(ext_a_is_e1_in),
        .line_is_e1_in(line_is_e1_in),
        .src_loss_in(loss_a_in),
        .src_out(src_a)
    );

    rcoc_src_monitor u_src_b (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .src_sel_in(src_sel_b_in),
        .ext_is_e1_in(ext_b_is_e1_in),
        .line_is_e1_in(line_is_e1_in),
        .src_loss_in(loss_b_in),
        .src_out(src_b)
    );

    //////////////////////////////////////////////////////////////////////////
    // Wishbone slave and configuration register.
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] stat_word;
    logic [31:0] rd_data_next;

    wire bus_req = wb_cyc_in && wb_stb_in;
    wire hit_cfg = (wb_adr_in[11:2] == RCOC_CFG_ADDR[11:2]);
    wire hit_stat = (wb_adr_in[11:2] == RCOC_STAT_ADDR[11:2]);
    // The write lands on the edge where the master sees ack high.
    wire cfg_wr = bus_req && wb_we_in && wb_ack_out && hit_cfg &&
                  wb_sel_in[0];

    assign cfg_next = cfg_wr ? (wb_dat_in[7:0] & RCOC_CFG_MASK) : cfg_reg;
    assign rd_data_next = hit_cfg ? {24'h0, cfg_reg} :
                          hit_stat ? {24'h0, stat_word} : 32'h0;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            cfg_reg <= RCOC_CFG_RESET;
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            wb_ack_out <= bus_req && !wb_ack_out;
            wb_dat_out <= rd_data_next;
        end
    end

    wire ja_skip = cfg_reg[RCOC_JA_SKIP_BIT];
    wire hold_high = cfg_reg[RCOC_HOLD_BIT];
    wire synth_skip = cfg_reg[RCOC_SYNTH_SKIP_BIT];
    wire free_run = cfg_reg[RCOC_FREE_BIT];
    wire [2:0] rate_code = cfg_reg[RCOC_RATE_LSB +: RCOC_RATE_W];

    //////////////////////////////////////////////////////////////////////////
    // Output A decision.
    rcoc_a_mode_t a_live_mode;
    rcoc_a_mode_t a_ext_lost_mode;
    rcoc_a_mode_t a_rec_lost_mode;
    rcoc_a_mode_t a_mode_next;

    // Free-run is only looked at while the synthesizer is in the path.
    assign a_live_mode = synth_skip ? RCOC_A_DIRECT :
                         free_run ? RCOC_A_FREE :
                         RCOC_A_LOCKED;
    // Holdover level plays no part for a lost external input.
    assign a_ext_lost_mode = (!synth_skip && free_run) ?
                             RCOC_A_FREE : RCOC_A_HIGH;
    assign a_rec_lost_mode = synth_skip ?
                             (hold_high ? RCOC_A_HIGH :
                              RCOC_A_LINE_FREE) :
                             free_run ? RCOC_A_FREE :
                             hold_high ? RCOC_A_HIGH :
                             RCOC_A_FREE;
    assign a_mode_next = !src_a.lost ? a_live_mode :
                         src_a.external ? a_ext_lost_mode : a_rec_lost_mode;

    wire [31:0] a_line_hz = src_a.is_e1 ? RCOC_HZ_E1 : RCOC_HZ_T1;
    wire [31:0] a_table_hz = rcoc_rate_hz(rate_code);
    // In locked mode code 000 follows the source rate.
    wire [31:0] a_locked_hz = (rate_code == RCOC_RATE_LINE) ?
                              a_line_hz : a_table_hz;
    wire [31:0] a_freq_next =
        (a_mode_next == RCOC_A_LOCKED) ? a_locked_hz :
        (a_mode_next == RCOC_A_FREE) ? a_table_hz :
        (a_mode_next == RCOC_A_DIRECT) ? a_line_hz :
        (a_mode_next == RCOC_A_LINE_FREE) ? a_line_hz : RCOC_HZ_NONE;
    // The code means nothing to the output once the synthesizer is out.
    wire [2:0] a_rate_next =
        synth_skip ? RCOC_RATE_LINE : rate_code;
    wire a_undef_next =
        ((a_mode_next == RCOC_A_FREE) &&
         ((rate_code == RCOC_RATE_LINE) || (rate_code == RCOC_RATE_RSVD))) ||
        ((a_mode_next == RCOC_A_LOCKED) &&
         (rate_code == RCOC_RATE_RSVD));
    // The skip path select matters only for a recovered channel clock.
    wire a_ja_next = src_a.recovered && ja_skip;

    //////////////////////////////////////////////////////////////////////////
    // Output B decision.
    rcoc_b_mode_t b_mode_next;

    assign b_mode_next = !src_b.lost ? RCOC_B_FOLLOW :
                         hold_high ? RCOC_B_HIGH :
                         RCOC_B_LINE_FREE;
    wire [31:0] b_freq_next = (b_mode_next == RCOC_B_HIGH) ? RCOC_HZ_NONE :
                              src_b.is_e1 ? RCOC_HZ_E1 : RCOC_HZ_T1;
    wire b_ja_next = src_b.recovered && ja_skip;

    //////////////////////////////////////////////////////////////////////////
    // Status word and output registers.
    assign stat_word[RCOC_STAT_AMODE_LSB +: 3] = ref_a_mode_out;
    assign stat_word[RCOC_STAT_BMODE_LSB +: 2] = ref_b_mode_out;
    assign stat_word[RCOC_STAT_ALOST_BIT] = src_a.lost;
    assign stat_word[RCOC_STAT_BLOST_BIT] = src_b.lost;
    assign stat_word[RCOC_STAT_UNDEF_BIT] = ref_a_code_undefined_out;

    // Registering every decision keeps glitches off the clock muxes.
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ref_a_mode_out <= RCOC_A_LOCKED;
            ref_a_rate_code_out <= RCOC_RATE_LINE;
            ref_a_freq_hz_out <= RCOC_HZ_NONE;
            ref_a_code_undefined_out <= 1'b0;
            ref_a_ja_skip_out <= 1'b0;
            ref_b_mode_out <= RCOC_B_FOLLOW;
            ref_b_freq_hz_out <= RCOC_HZ_NONE;
            ref_b_ja_skip_out <= 1'b0;
        end else begin
            ref_a_mode_out <= a_mode_next;
            ref_a_rate_code_out <= a_rate_next;
            ref_a_freq_hz_out <= a_freq_next;
            ref_a_code_undefined_out <= a_undef_next;
            ref_a_ja_skip_out <= a_ja_next;
            ref_b_mode_out <= b_mode_next;
            ref_b_freq_hz_out <= b_freq_next;
            ref_b_ja_skip_out <= b_ja_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_skip_write;
        bus_req && wb_we_in && wb_ack_out && hit_cfg && wb_sel_in[0] &&
        wb_dat_in[RCOC_SYNTH_SKIP_BIT];
    endsequence

    sequence s_b_loss_high;
        src_b.lost && hold_high;
    endsequence

    property p_ja_external;
        src_a.external && ja_skip |=> !ref_a_ja_skip_out;
    endproperty
    a_ja_external: assert property (p_ja_external)
        else $error("jitter skip leaked onto an external source");

    property p_ja_path;
        src_b.recovered |=> (ref_b_ja_skip_out == $past(ja_skip));
    endproperty
    a_ja_path: assert property (p_ja_path)
        else $error("output B recovered path does not follow skip bit");

    property p_ja_default;
        !ja_skip |=> !ref_a_ja_skip_out && !ref_b_ja_skip_out;
    endproperty
    a_ja_default: assert property (p_ja_default)
        else $error("attenuator bypassed while skip bit is clear");

    property p_skip_write;
        s_skip_write ##1 !src_a.lost |=> ref_a_mode_out == RCOC_A_DIRECT;
    endproperty
    a_skip_write: assert property (p_skip_write)
        else $error("synth skip write did not route output A around");

    property p_locked;
        !src_a.lost && !synth_skip && !free_run |=>
            ref_a_mode_out == RCOC_A_LOCKED;
    endproperty
    a_locked: assert property (p_locked)
        else $error("output A not locked in normal operation");

    property p_free;
        !src_a.lost && !synth_skip && free_run |=>
            ref_a_mode_out == RCOC_A_FREE;
    endproperty
    a_free: assert property (p_free)
        else $error("output A not free running with free-run set");

    property p_ext_lost;
        src_a.lost && src_a.external |=>
            ref_a_mode_out == (($past(!synth_skip) && $past(free_run)) ?
                               RCOC_A_FREE : RCOC_A_HIGH);
    endproperty
    a_ext_lost: assert property (p_ext_lost)
        else $error("wrong output A for a lost external input");

    property p_rec_lost_synth;
        src_a.lost && src_a.recovered && !synth_skip && !free_run |=>
            ref_a_mode_out == ($past(hold_high) ? RCOC_A_HIGH : RCOC_A_FREE);
    endproperty
    a_rec_lost_synth: assert property (p_rec_lost_synth)
        else $error("wrong output A for a lost channel with synthesizer");

    property p_rec_lost_skip;
        src_a.lost && src_a.recovered && synth_skip |=>
            ref_a_mode_out == ($past(hold_high) ? RCOC_A_HIGH :
                               RCOC_A_LINE_FREE);
    endproperty
    a_rec_lost_skip: assert property (p_rec_lost_skip)
        else $error("wrong output A for a lost channel without synthesizer");

    property p_rec_lost_free;
        src_a.lost && src_a.recovered && !synth_skip && free_run |=>
            ref_a_mode_out == RCOC_A_FREE;
    endproperty
    a_rec_lost_free: assert property (p_rec_lost_free)
        else $error("output A left free-run on a lost channel");

    property p_rate_gate;
        synth_skip |=> ref_a_rate_code_out == RCOC_RATE_LINE;
    endproperty
    a_rate_gate: assert property (p_rate_gate)
        else $error("rate code applied with synthesizer skipped");

    property p_line_code;
        !src_a.lost && !synth_skip && !free_run &&
        rate_code == RCOC_RATE_LINE |=>
            ref_a_freq_hz_out == ($past(src_a.is_e1) ? RCOC_HZ_E1 :
                                  RCOC_HZ_T1);
    endproperty
    a_line_code: assert property (p_line_code)
        else $error("code 000 did not reproduce the source rate");

    property p_top_code;
        !src_a.lost && !synth_skip && rate_code == 3'h7 |=>
            ref_a_freq_hz_out == RCOC_HZ_32M;
    endproperty
    a_top_code: assert property (p_top_code)
        else $error("code 111 did not give 32.768 MHz");

    property p_free_undef;
        !src_a.lost && !synth_skip && free_run &&
        rate_code == RCOC_RATE_LINE |=> ref_a_code_undefined_out;
    endproperty
    a_free_undef: assert property (p_free_undef)
        else $error("free-running code 000 not flagged undefined");

    property p_b_free;
        src_b.lost && !hold_high |=>
            ref_b_mode_out == RCOC_B_LINE_FREE &&
            ref_b_freq_hz_out != RCOC_HZ_NONE;
    endproperty
    a_b_free: assert property (p_b_free)
        else $error("output B not free running on loss");

    property p_b_high;
        s_b_loss_high ##1 s_b_loss_high |=>
            ref_b_mode_out == RCOC_B_HIGH [*1] ##0
            ref_b_freq_hz_out == RCOC_HZ_NONE;
    endproperty
    a_b_high: assert property (p_b_high)
        else $error("output B not held high on loss");

    property p_b_live;
        !src_b.lost |=> ref_b_mode_out == RCOC_B_FOLLOW;
    endproperty
    a_b_live: assert property (p_b_live)
        else $error("output B holdover acted without a loss");

    property p_ack_once;
        bus_req && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("bus acknowledge is not a single cycle");
endmodule

/* core/rcoc_pkg.sv */
package rcoc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map and bus sizes.
    localparam int RCOC_ADR_W = 12;
    localparam logic [11:0] RCOC_CFG_ADDR = 12'h200;
    localparam logic [11:0] RCOC_STAT_ADDR = 12'h204;
    localparam logic [7:0] RCOC_CFG_RESET = 8'h00;

    // Configuration register fields.
    localparam int RCOC_JA_SKIP_BIT = 6;
    localparam int RCOC_HOLD_BIT = 5;
    localparam int RCOC_SYNTH_SKIP_BIT = 4;
    localparam int RCOC_FREE_BIT = 3;
    localparam int RCOC_RATE_LSB = 0;
    localparam int RCOC_RATE_W = 3;
    localparam logic [7:0] RCOC_CFG_MASK = 8'h7f;

    // Status register fields.
    localparam int RCOC_STAT_AMODE_LSB = 0;
    localparam int RCOC_STAT_BMODE_LSB = 3;
    localparam int RCOC_STAT_ALOST_BIT = 5;
    localparam int RCOC_STAT_BLOST_BIT = 6;
    localparam int RCOC_STAT_UNDEF_BIT = 7;

    // Source select codes up to this one name a recovered channel clock.
    localparam logic [4:0] RCOC_LAST_CHANNEL = 5'h10;

    // Rate codes with a special meaning.
    localparam logic [2:0] RCOC_RATE_LINE = 3'h0;
    localparam logic [2:0] RCOC_RATE_RSVD = 3'h3;

    // Output frequencies in Hz.
    localparam logic [31:0] RCOC_HZ_NONE = 32'h0;
    localparam logic [31:0] RCOC_HZ_T1 = 32'h178f40;
    localparam logic [31:0] RCOC_HZ_E1 = 32'h1f4000;
    localparam logic [31:0] RCOC_HZ_8K = 32'h1f40;
    localparam logic [31:0] RCOC_HZ_64K = 32'hfa00;
    localparam logic [31:0] RCOC_HZ_4M = 32'h3e8000;
    localparam logic [31:0] RCOC_HZ_8M = 32'h7d0000;
    localparam logic [31:0] RCOC_HZ_19M = 32'h128a180;
    localparam logic [31:0] RCOC_HZ_32M = 32'h1f40000;

    typedef enum logic [2:0] {
        RCOC_A_LOCKED,
        RCOC_A_FREE,
        RCOC_A_DIRECT,
        RCOC_A_LINE_FREE,
        RCOC_A_HIGH
    } rcoc_a_mode_t;

    typedef enum logic [1:0] {
        RCOC_B_FOLLOW,
        RCOC_B_LINE_FREE,
        RCOC_B_HIGH
    } rcoc_b_mode_t;

    // Fixed rates of the synthesizer; the line rate and reserved codes
    // give zero here and are resolved by the caller.
    function automatic logic [31:0] rcoc_rate_hz(input logic [2:0] code);
        case (code)
            3'h1: rcoc_rate_hz = RCOC_HZ_8K;
            3'h2: rcoc_rate_hz = RCOC_HZ_64K;
            3'h4: rcoc_rate_hz = RCOC_HZ_4M;
            3'h5: rcoc_rate_hz = RCOC_HZ_8M;
            3'h6: rcoc_rate_hz = RCOC_HZ_19M;
            3'h7: rcoc_rate_hz = RCOC_HZ_32M;
            default: rcoc_rate_hz = RCOC_HZ_NONE;
        endcase
    endfunction

endpackage

/* core/rcoc_src_if.sv */
interface rcoc_src_if;
    logic recovered;
    logic external;
    logic lost;
    logic is_e1;

    modport mon (output recovered, output external, output lost,
                 output is_e1);
    modport ctl (input recovered, input external, input lost, input is_e1);
endinterface

/* core/rcoc_src_monitor.sv */
module rcoc_src_monitor (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Source selection from the neighbouring source register.
    input wire logic [4:0] src_sel_in,
    input wire logic ext_is_e1_in,
    input wire logic line_is_e1_in,
    // Loss indication from the clock monitor pin.
    input wire logic src_loss_in,
    // Classified source towards the output control.
    rcoc_src_if.mon src_out
);
    import rcoc_pkg::*;

    logic loss_meta_reg;
    logic loss_sync_reg;

    // The loss indication is asynchronous, so it passes two flops first.
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            loss_meta_reg <= 1'b0;
            loss_sync_reg <= 1'b0;
        end else begin
            loss_meta_reg <= src_loss_in;
            loss_sync_reg <= loss_meta_reg;
        end
    end

    assign src_out.recovered = (src_sel_in <= RCOC_LAST_CHANNEL);
    assign src_out.external = (src_sel_in > RCOC_LAST_CHANNEL);
    assign src_out.lost = loss_sync_reg;
    assign src_out.is_e1 = src_out.external ? ext_is_e1_in : line_is_e1_in;
endmodule

/* tb/rcoc_ref_sink.sv */
module rcoc_ref_sink (
    // Clock.
    input wire logic clk_sys_in,
    // Reference outputs seen as nominal rates.
    input wire logic [31:0] a_hz_in,
    input wire logic [31:0] b_hz_in,
    // Whether each reference carries usable edges.
    output logic a_alive_out,
    output logic b_alive_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // A steady level has no edges, so timing circuits treat it as absent.
    always_ff @(posedge clk_sys_in) begin
        a_alive_out <= (a_hz_in != 32'h0);
        b_alive_out <= (b_hz_in != 32'h0);
    end
endmodule

/* tb/reference_clock_output_control_bench.sv */
module reference_clock_output_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rcoc_pkg::*;

    typedef struct {
        logic [7:0] cfg;
        logic [4:0] sel;
        logic loss;
        logic e1;
        rcoc_a_mode_t am;
        logic [31:0] af;
        rcoc_b_mode_t bm;
        logic [31:0] bf;
        logic ja;
    } rcoc_row_t;

    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [11:0] wb_adr_in = 12'h0;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    logic [4:0] sel = 5'h0;
    logic loss = 1'b0;
    logic e1 = 1'b0;
    rcoc_a_mode_t a_mode;
    logic [2:0] a_code;
    logic [31:0] a_hz;
    logic a_undef;
    logic a_ja;
    rcoc_b_mode_t b_mode;
    logic [31:0] b_hz;
    logic b_ja;
    logic a_alive;
    logic b_alive;
    logic [31:0] rd;
    int num_errors = 0;
    int n_tests = 0;

    rcoc_row_t rows[18] = '{
        '{8'h01, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_8K, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h00, 0, 0, 1, RCOC_A_LOCKED, RCOC_HZ_E1, RCOC_B_FOLLOW,
          RCOC_HZ_E1, 0},
        '{8'h02, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_64K, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h04, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_4M, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h05, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_8M, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h06, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_19M, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h07, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_32M, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h0c, 0, 0, 0, RCOC_A_FREE, RCOC_HZ_4M, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h12, 0, 0, 0, RCOC_A_DIRECT, RCOC_HZ_T1, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h41, 0, 0, 0, RCOC_A_LOCKED, RCOC_HZ_8K, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 1},
        '{8'h41, 17, 0, 0, RCOC_A_LOCKED, RCOC_HZ_8K, RCOC_B_FOLLOW,
          RCOC_HZ_T1, 0},
        '{8'h01, 0, 1, 0, RCOC_A_FREE, RCOC_HZ_8K, RCOC_B_LINE_FREE,
          RCOC_HZ_T1, 0},
        '{8'h21, 0, 1, 1, RCOC_A_HIGH, RCOC_HZ_NONE, RCOC_B_HIGH,
          RCOC_HZ_NONE, 0},
        '{8'h29, 0, 1, 0, RCOC_A_FREE, RCOC_HZ_8K, RCOC_B_HIGH,
          RCOC_HZ_NONE, 0},
        '{8'h10, 0, 1, 1, RCOC_A_LINE_FREE, RCOC_HZ_E1, RCOC_B_LINE_FREE,
          RCOC_HZ_E1, 0},
        '{8'h30, 0, 1, 0, RCOC_A_HIGH, RCOC_HZ_NONE, RCOC_B_HIGH,
          RCOC_HZ_NONE, 0},
        '{8'h29, 31, 1, 0, RCOC_A_FREE, RCOC_HZ_8K, RCOC_B_HIGH,
          RCOC_HZ_NONE, 0},
        '{8'h19, 17, 1, 0, RCOC_A_HIGH, RCOC_HZ_NONE, RCOC_B_LINE_FREE,
          RCOC_HZ_T1, 0}
    };
    // Rows

    rcoc_top i_rcoc_top (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .src_sel_a_in(sel), .src_sel_b_in(sel), .ext_a_is_e1_in(1'b0),
        .ext_b_is_e1_in(1'b0), .line_is_e1_in(e1), .loss_a_in(loss),
        .loss_b_in(loss), .ref_a_mode_out(a_mode),
        .ref_a_rate_code_out(a_code), .ref_a_freq_hz_out(a_hz),
        .ref_a_code_undefined_out(a_undef), .ref_a_ja_skip_out(a_ja),
        .ref_b_mode_out(b_mode), .ref_b_freq_hz_out(b_hz),
        .ref_b_ja_skip_out(b_ja));

    rcoc_ref_sink i_rcoc_ref_sink (.clk_sys_in(clk_sys_in), .a_hz_in(a_hz),
        .b_hz_in(b_hz), .a_alive_out(a_alive), .b_alive_out(b_alive));

    always #10 clk_sys_in = ~clk_sys_in;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // The request is held until ack is sampled high; no latency is assumed.
    task automatic wb(input logic we, input logic [11:0] adr,
                      input logic [7:0] dat, input logic [3:0] bsel);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_sel_in <= bsel;
        wb_dat_in <= {24'h0, dat};
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        chk("wb_ack", 32'h1, {31'h0, wb_ack_out});
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
    endtask

    task automatic settle;
        repeat (4) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic final_report;
        $display("Errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        $display("[ERR] watchdog expected done seen hang");
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        wb(1'b0, RCOC_CFG_ADDR, 8'h0, 4'hf);
        chk("cfg_reset", {24'h0, RCOC_CFG_RESET}, rd);
        foreach (rows[i]) begin
            @(posedge clk_sys_in);
            sel <= rows[i].sel;
            loss <= rows[i].loss;
            e1 <= rows[i].e1;
            wb(1'b1, RCOC_CFG_ADDR, rows[i].cfg, 4'h1);
            settle();
            chk("a_mode", 32'(rows[i].am), 32'(a_mode));
            chk("a_hz", rows[i].af, a_hz);
            chk("b_mode", 32'(rows[i].bm), 32'(b_mode));
            chk("b_hz", rows[i].bf, b_hz);
            chk("a_ja", {31'h0, rows[i].ja}, {31'h0, a_ja});
            chk("b_ja", {31'h0, rows[i].ja}, {31'h0, b_ja});
            chk("a_alive", {31'h0, rows[i].af != 0}, {31'h0, a_alive});
            chk("b_alive", {31'h0, rows[i].bf != 0}, {31'h0, b_alive});
        end
        // Bit 7 is reserved and must not stick.
        wb(1'b1, RCOC_CFG_ADDR, 8'hff, 4'hf);
        wb(1'b1, RCOC_CFG_ADDR, 8'h05, 4'he);
        wb(1'b0, RCOC_CFG_ADDR, 8'h0, 4'hf);
        chk("cfg_mask", 32'h7f, rd);
        wb(1'b0, 12'h300, 8'h0, 4'hf);
        chk("unmapped", 32'h0, rd);
        @(posedge clk_sys_in);
        sel <= 5'h0;
        loss <= 1'b0;
        wb(1'b1, RCOC_CFG_ADDR, 8'h17, 4'h1);
        settle();
        chk("a_code", 32'h0, {29'h0, a_code});
        wb(1'b1, RCOC_CFG_ADDR, 8'h03, 4'h1);
        settle();
        chk("a_undef", 32'h1, {31'h0, a_undef});
        chk("a_hz", 32'h0, a_hz);
        wb(1'b1, RCOC_CFG_ADDR, 8'h08, 4'h1);
        settle();
        chk("a_undef", 32'h1, {31'h0, a_undef});
        wb(1'b0, RCOC_STAT_ADDR, 8'h0, 4'hf);
        chk("status", 32'h81, rd);
        final_report();
    end
endmodule
